// File: hdl/hwie_pkg.sv
/*
 * constants for the hold-release and interrupt enable block.
 * assumes the cpu decoder presents one-cycle load strobes with an 8-bit immediate.
 */
// Function
// - load eight hold-release bits in one cycle
// - bit 0: divider overflow ends hold
// - bit 1: timer 0 underflow ends hold
// - bit 2: change sense port ends hold
// - bit 4: interrupt pin falling edge ends hold
// - bit 5: serial receive done ends hold
// - bit 6: serial transmit done ends hold
// - bit 7: timer 1 underflow ends hold
// - load interrupt enables, same bit order
// - port change counts only on enabled pins
package hwie_pkg;
	localparam int        EN_W        = 8;
	localparam int        PORT_W      = 4;
	// ------------------------------------------------------------
	// event bit positions
	// ------------------------------------------------------------
	localparam int        BIT_DIV0    = 0;
	localparam int        BIT_TMR0    = 1;
	localparam int        BIT_PORT    = 2;
	localparam int        BIT_RSVD    = 3;
	localparam int        BIT_PIN     = 4;
	localparam int        BIT_RX      = 5;
	localparam int        BIT_TX      = 6;
	localparam int        BIT_TMR1    = 7;
	// ------------------------------------------------------------
	// reset values and reserved-bit mask
	// ------------------------------------------------------------
	localparam logic [7:0] HOLD_EN_RST = 8'h00;
	localparam logic [7:0] IRQ_EN_RST  = 8'h00;
	localparam logic [3:0] PORT_EN_RST = 4'h0;
	localparam logic [7:0] RSVD_MASK   = 8'hF7;
endpackage : hwie_pkg

// File: hdl/hwie_port_change.sv
/*
 * change detector for the four change-sense port pins.
 * assumes pin levels already synchronous to i_ref_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module hwie_port_change
	import hwie_pkg::*;
(
	// clock and reset
	input  wire logic                          i_ref_clk,
	input  wire logic                          i_rstn,
	// pins and per-pin enables
	input  wire logic [hwie_pkg::PORT_W-1:0]   i_pins,
	input  wire logic [hwie_pkg::PORT_W-1:0]   i_pin_en,
	// change pulse
	output logic                               o_change
);
	import hwie_pkg::*;

	logic [PORT_W-1:0] prev_ff;
	logic              seen_ff;

	// ------------------------------------------------------------
	// edge compare
	// ------------------------------------------------------------
	// first sample after reset only primes the history, so no false change
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rstn)
		begin
			prev_ff <= PORT_EN_RST;
			seen_ff <= 1'b0;
		end
		else
		begin
			prev_ff <= i_pins;
			seen_ff <= 1'b1;
		end
	end

	assign o_change = seen_ff && |((prev_ff ^ i_pins) & i_pin_en);
endmodule : hwie_port_change
`default_nettype wire

// File: hdl/hwie_top.sv
/*
 * hold-release and interrupt enable sets, loaded by immediate instructions.
 * assumes event inputs are one-cycle pulses synchronous to i_ref_clk,
 * except the interrupt pin and port pins which are levels.
 */
`timescale 1ns/1ps
`default_nettype none
module hwie_top
	import hwie_pkg::*;
(
	// clock and reset
	input  wire logic                          i_ref_clk,
	input  wire logic                          i_rstn,
	// instruction decoder loads
	input  wire logic                          i_ld_hold_en,
	input  wire logic                          i_ld_irq_en,
	input  wire logic                          i_ld_port_en,
	input  wire logic [hwie_pkg::EN_W-1:0]     i_imm,
	// event sources
	input  wire logic                          i_div0_ovf,
	input  wire logic                          i_tmr0_udf,
	input  wire logic [hwie_pkg::PORT_W-1:0]   i_change_sense_port,
	input  wire logic                          i_int_pin,
	input  wire logic                          i_rx_done,
	input  wire logic                          i_tx_done,
	input  wire logic                          i_tmr1_udf,
	// results
	output logic [hwie_pkg::EN_W-1:0]          o_hold_release_enable,
	output logic [hwie_pkg::EN_W-1:0]          o_interrupt_enable,
	output logic [hwie_pkg::PORT_W-1:0]        o_port_change_enable,
	output logic                               o_hold_release,
	output logic [hwie_pkg::EN_W-1:0]          o_irq_req
);
	import hwie_pkg::*;

	logic [EN_W-1:0]   hold_en_ff;
	logic [EN_W-1:0]   irq_en_ff;
	logic [PORT_W-1:0] port_en_ff;
	logic              pin_ff;
	logic              port_change;
	logic [EN_W-1:0]   events;
	logic [EN_W-1:0]   nxt_wake;
	logic [EN_W-1:0]   nxt_irq;
	logic              wake_ff;
	logic [EN_W-1:0]   irq_ff;

	// both enable sets share the reserved-bit rule, so one place owns it
	function automatic logic [EN_W-1:0] mask_rsvd(input logic [EN_W-1:0] value);
		return value & RSVD_MASK;
	endfunction : mask_rsvd

	// ------------------------------------------------------------
	// enable registers
	// ------------------------------------------------------------
	// reserved bit 3 is forced to zero so it can never enable anything
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rstn)
			hold_en_ff <= HOLD_EN_RST;
		else if (i_ld_hold_en)
			hold_en_ff <= mask_rsvd(i_imm);
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rstn)
			irq_en_ff <= IRQ_EN_RST;
		else if (i_ld_irq_en)
			irq_en_ff <= mask_rsvd(i_imm);
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rstn)
			port_en_ff <= PORT_EN_RST;
		else if (i_ld_port_en)
			port_en_ff <= i_imm[PORT_W-1:0];
	end

	// ------------------------------------------------------------
	// event sources
	// ------------------------------------------------------------
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rstn)
			pin_ff <= 1'b1;
		else
			pin_ff <= i_int_pin;
	end

	hwie_port_change u_port_change (
		.i_ref_clk (i_ref_clk),
		.i_rstn    (i_rstn),
		.i_pins    (i_change_sense_port),
		.i_pin_en  (port_en_ff),
		.o_change  (port_change)
	);

	always_comb
	begin
		events           = '0;
		events[BIT_DIV0] = i_div0_ovf;
		events[BIT_TMR0] = i_tmr0_udf;
		events[BIT_PORT] = port_change;
		events[BIT_PIN]  = pin_ff & ~i_int_pin;
		events[BIT_RX]   = i_rx_done;
		events[BIT_TX]   = i_tx_done;
		events[BIT_TMR1] = i_tmr1_udf;
		nxt_wake         = events & hold_en_ff;
		nxt_irq          = events & irq_en_ff;
	end

	// ------------------------------------------------------------
	// registered outputs
	// ------------------------------------------------------------
	// one cycle of latency buys glitch-free outputs toward the core
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rstn)
		begin
			wake_ff <= 1'b0;
			irq_ff  <= '0;
		end
		else
		begin
			wake_ff <= |nxt_wake;
			irq_ff  <= nxt_irq;
		end
	end

	assign o_hold_release_enable = hold_en_ff;
	assign o_interrupt_enable    = irq_en_ff;
	assign o_port_change_enable  = port_en_ff;
	assign o_hold_release        = wake_ff;
	assign o_irq_req             = irq_ff;
endmodule : hwie_top
`default_nettype wire

// File: test/hwie_evt_src.sv
/* event-source model: one request pulses one chosen source.
   assumes requests arrive at falling edges. */
`timescale 1ns/1ps
`default_nettype none
module hwie_evt_src (
	input	wire logic		i_ref_clk,
	input	wire logic		i_go,
	input	wire logic [2:0]	i_sel,
	output	logic [7:0]		o_ev,
	output	logic [3:0]		o_port
);
	initial o_ev = 8'h10;
	initial o_port = 4'h0;
	// pin rests high, so one request gives exactly one falling edge
	always @(negedge i_ref_clk)
	begin
		o_ev <= i_go ? 8'h10 ^ (8'h01 << i_sel) : 8'h10;
		if (i_go && i_sel == 3'h2)
			o_port <= o_port ^ 4'h1;
	end
endmodule : hwie_evt_src
`default_nettype wire

// File: test/hwie_top_sva.sv
/* port assertions for hwie_top.
   assumes a single clock and a synchronous active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module hwie_top_sva
	import hwie_pkg::*;
(
	input	wire logic		i_ref_clk,
	input	wire logic		i_rstn,
	input	wire logic		i_ld_hold_en,
	input	wire logic		i_ld_irq_en,
	input	wire logic [EN_W-1:0]	i_imm,
	input	wire logic		i_div0_ovf,
	input	wire logic		i_tmr1_udf,
	input	wire logic		i_tx_done,
	input	wire logic [EN_W-1:0]	o_hold_release_enable,
	input	wire logic [EN_W-1:0]	o_interrupt_enable,
	input	wire logic		o_hold_release,
	input	wire logic [EN_W-1:0]	o_irq_req
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_rstn);
	AST_LDH: assert property (i_ld_hold_en |=>
		o_hold_release_enable == ($past(i_imm) & RSVD_MASK)) else $error("hold load");
	AST_LDI: assert property (i_ld_irq_en |=>
		o_interrupt_enable == ($past(i_imm) & RSVD_MASK)) else $error("irq load");
	AST_KEEP: assert property (!i_ld_hold_en |=>
		$stable(o_hold_release_enable)) else $error("hold enables moved");
	AST_DIV: assert property (i_div0_ovf && o_hold_release_enable[BIT_DIV0] |=>
		o_hold_release) else $error("divider wake lost");
	AST_T1: assert property (i_tmr1_udf && o_hold_release_enable[BIT_TMR1] |=>
		o_hold_release) else $error("timer 1 wake lost");
	AST_TX: assert property (i_tx_done && o_interrupt_enable[BIT_TX] |=>
		o_irq_req[BIT_TX]) else $error("transmit irq lost");
	AST_RSV: assert property (o_irq_req[BIT_RSVD] == 1'h0)
		else $error("reserved irq raised");
	AST_IRQ0: assert property (o_irq_req[BIT_DIV0] |->
		$past(i_div0_ovf && o_interrupt_enable[BIT_DIV0])) else $error("stray irq");
endmodule : hwie_top_sva
bind hwie_top hwie_top_sva hwie_top_sva_i (.*);
`default_nettype wire

// File: test/tb.sv
/* self-checking bench for hwie_top.
   assumes hwie_evt_src as the event side. */
`timescale 1ns/1ps
`default_nettype none
module tb;
	import hwie_pkg::*;
	logic		clk = 0, rstn = 0, go = 0, hr;
	logic [2:0]	ld = 0, sel = 0;
	logic [7:0]	imm = 0, ev, hre, ie, irq;
	logic [3:0]	prt, pe;
	int		bad_count = 0, checks = 0;
	always #25 clk = ~clk;
	hwie_evt_src hwie_evt_src_i (.i_ref_clk(clk), .i_go(go), .i_sel(sel), .o_ev(ev), .o_port(prt));
	hwie_top hwie_top_i (.i_ref_clk(clk), .i_rstn(rstn), .i_ld_hold_en(ld[0]), .i_ld_irq_en(ld[1]),
		.i_ld_port_en(ld[2]), .i_imm(imm), .i_div0_ovf(ev[0]), .i_tmr0_udf(ev[1]),
		.i_change_sense_port(prt), .i_int_pin(ev[4]), .i_rx_done(ev[5]), .i_tx_done(ev[6]),
		.i_tmr1_udf(ev[7]), .o_hold_release_enable(hre), .o_interrupt_enable(ie),
		.o_port_change_enable(pe), .o_hold_release(hr), .o_irq_req(irq));
	task chk(input string n, input logic [7:0] e, g);
		checks++;
		if (g !== e)
		begin
			bad_count++;
			$display("MISMATCH %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task stop_test;
		$display("bad_count %0d checks %0d", bad_count, checks);
		if (bad_count == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : stop_test
	task run(input logic [7:0] h, q, input logic [3:0] p);
		logic e;
		@(negedge clk) {ld, imm} <= {3'h4, 4'h0, p};
		@(negedge clk) {ld, imm} <= {3'h1, h};
		@(negedge clk) {ld, imm} <= {3'h2, q};
		@(negedge clk) ld <= 3'h0;
		chk("hold_en", h & RSVD_MASK, hre);
		chk("irq_en", q & RSVD_MASK, ie);
		chk("port_en", {4'h0, p}, {4'h0, pe});
		for (int s = 0; s < 8; s++)
			if (s != BIT_RSVD)
			begin
				e = (s != BIT_PORT) || p[0];
				@(negedge clk) {go, sel} <= {1'h1, 3'(s)};
				@(negedge clk) go <= 1'h0;
				@(negedge clk) chk("wake", {7'h0, h[s] & e}, {7'h0, hr});
				chk("irq", {7'h0, q[s] & e} << s, irq);
			end
	endtask : run
	initial
	begin
		repeat (6) @(negedge clk);
		rstn <= 1'h1;
		run(8'hFF, 8'hFF, 4'hF);
		run(8'hAA, 8'h55, 4'h0);
		run(8'h24, 8'h24, 4'hE);
		stop_test();
	end
endmodule : tb
`default_nettype wire
